// ===== hdl/dtc_params.svh
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ****************************************
// register offsets and fields
// ****************************************
`define DTC_REG_CMD 8'h00
`define DTC_REG_CFG 8'h04
`define DTC_REG_STAT 8'h08
`define DTC_CMD_BG_LSB 4
`define DTC_CMD_ADDR_LSB 6
`define DTC_CFG_CRC 0
`define DTC_CFG_MASK 1
`define DTC_CFG_DLL 2
`define DTC_CFG_BC4F 3
`define DTC_CFG_MR0WR 4
`define DTC_CFG_RPRE 5
`define DTC_CFG_WPRE 6
`define DTC_CFG_WL_LSB 8
`define DTC_CFG_MR0_LSB 16
`define DTC_CFG_USED 24'h1F1F7F
`define DTC_STAT_BUSY 0
`define DTC_STAT_REFUSED 1
`define DTC_STAT_LATE 2
`define DTC_STAT_PREBAD 3

// ****************************************
// pin-side address fields
// ****************************************
`define DTC_MR_SEL_LSB 14
`define DTC_MR_FOUR 3'h4
`define DTC_MR_SEVEN 3'h7
`define DTC_A_RPRE 11
`define DTC_A_WPRE 12

// ****************************************
// timing, ps unless named in cycles; rates in MT/s
// ****************************************
`define DTC_TCK_PS 80000
`define DTC_WR_PS 15000
`define DTC_WR_CRC_DM_PS 20000
`define DTC_WTRS_PS 2500
`define DTC_WTRL_PS 7500
`define DTC_WTRS_CD_PS 3750
`define DTC_WTRL_CD_PS 8750
`define DTC_REFI_PS 7800000
`define DTC_MOD_NCK 24
`define DTC_GEAR_EXTRA_NCK 4
`define DTC_MR7_NCK 5
`define DTC_BL8_START_NCK 4
`define DTC_BC4_START_NCK 2
`define DTC_RATE_FLOOR 1600
`define DTC_RATE_A 2400
`define DTC_RATE_B 2666
`define DTC_RATE_C 3200
`define DTC_RATE_DEF 3200

`endif

// ===== hdl/dtc_pkg.sv
package dtc_pkg;

    typedef enum logic [3:0] {
        DTC_NOP = 4'h0, DTC_ACT = 4'h1, DTC_RD = 4'h2, DTC_RDA = 4'h3,
        DTC_WR = 4'h4, DTC_WRA = 4'h5, DTC_PRE = 4'h6, DTC_REF = 4'h7,
        DTC_MRS = 4'h8, DTC_PDE = 4'h9, DTC_PDX = 4'hA, DTC_SYNC = 4'hB,
        DTC_ODT = 4'hC, DTC_GMRS = 4'hD
    } dtc_cmd_t;

    typedef enum logic [2:0] {
        DTC_L_IDLE = 3'b001,
        DTC_L_WAIT = 3'b010,
        DTC_L_ACK = 3'b100
    } dtc_lstate_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic [3:0] cmd;
        logic [1:0] bg;
        logic [16:0] addr;
        logic [23:0] cfg;
        logic req;
        logic ack_seen;
        logic busy;
        logic refused;
        logic late;
    } dtc_host_t;

    typedef struct packed {
        dtc_lstate_t state;
        logic req_seen;
        logic ack;
        logic refused;
        logic [3:0] cmd_o;
        logic [1:0] bg_o;
        logic [16:0] addr_o;
        logic cke;
        logic [1:0] last_wr_bg;
        logic gear_armed;
        logic [7:0] gear_el;
        logic [7:0] wr_since;
        logic [7:0] sync_since;
        logic [15:0] refi;
        logic late;
    } dtc_link_t;

    function automatic int dtc_ceil_cyc(input int ps, input int tck_ps);
        int n;
        n = (ps + tck_ps - 1) / tck_ps;
        return (n < 1) ? 1 : n;
    endfunction

    function automatic int dtc_floor_cyc(input int ps, input int tck_ps);
        int n;
        n = ps / tck_ps;
        return (n < 1) ? 1 : n;
    endfunction

    function automatic logic dtc_is_read(input logic [3:0] c);
        return (c == DTC_RD) || (c == DTC_RDA);
    endfunction

endpackage

// ===== hdl/dtc_sync.sv
`timescale 1ns/10ps
module dtc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dtc_sync_t;

    dtc_sync_t r, next_r;

    // no reset: this path also carries the reset into the link domain
    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign q = r.s2;
endmodule // dtc_sync

// ===== hdl/dtc_cnt.sv
`timescale 1ns/10ps
module dtc_cnt #(
    parameter int N = 1,
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [N-1:0] load,
    input wire logic [N*W-1:0] value,
    output logic [N-1:0] idle
);
    typedef struct packed {
        logic [N-1:0][W-1:0] cnt;
    } dtc_cnt_t;

    dtc_cnt_t r, next_r;

    always_comb begin
        next_r = r;
        for (int i = 0; i < N; i++) begin
            if (load[i]) begin
                next_r.cnt[i] = value[i*W +: W];
            end else if (r.cnt[i] != '0) begin
                next_r.cnt[i] = r.cnt[i] - 1'b1;
            end
        end
        if (rst) begin
            next_r = '0;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            idle[i] = (r.cnt[i] == '0);
        end
    end
endmodule // dtc_cnt

// ===== hdl/dtc_top.sv
`timescale 1ns/10ps
`include "dtc_params.svh"

// Overview of operation
// - reads and sync termination need locked DLL
// - write-to-powerdown uses write recovery rounded up
// - optionally use mode_reg_zero write-recovery cycles
// - powerdown entry may overlap activate, precharge, refresh
// - ns to cycles: divide by period, round up; refresh interval rounds down
// - CRC with mask uses combined write recovery
// - CRC with mask uses combined write-to-read times
// - slow clock allowed if refresh interval kept
// - geardown sync interval is even cycles
// - geardown waits mode update plus four, then update
// - write preamble two-cycle only at allowed rates
// - after mode_reg_seven, five cycles before non-MODE_REGISTER_SET_CMD
// - below 1600 MT/s use 1600 timing
module dtc_top
    import dtc_pkg::*;
#(
    parameter int DATA_RATE = `DTC_RATE_DEF,
    parameter int TCK_PS = `DTC_TCK_PS,
    parameter int MOD_NCK = `DTC_MOD_NCK
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic [3:0] ddr_cmd,
    output logic [1:0] ddr_bg,
    output logic [16:0] ddr_addr,
    output logic ddr_cke
);

    // ****************************************
    // derived timing
    // ****************************************
    localparam int WR_CYC = dtc_ceil_cyc(`DTC_WR_PS, TCK_PS);
    localparam int WRCD_CYC = dtc_ceil_cyc(`DTC_WR_CRC_DM_PS, TCK_PS);
    localparam int WTRS_CYC = dtc_ceil_cyc(`DTC_WTRS_PS, TCK_PS);
    localparam int WTRL_CYC = dtc_ceil_cyc(`DTC_WTRL_PS, TCK_PS);
    localparam int WTRSCD_CYC = dtc_ceil_cyc(`DTC_WTRS_CD_PS, TCK_PS);
    localparam int WTRLCD_CYC = dtc_ceil_cyc(`DTC_WTRL_CD_PS, TCK_PS);
    // interval is a longest time, so it rounds down
    localparam int REFI_CYC = dtc_floor_cyc(`DTC_REFI_PS, TCK_PS);
    localparam int RATE_EFF = (DATA_RATE < `DTC_RATE_FLOOR) ? `DTC_RATE_FLOOR
        : DATA_RATE;
    localparam bit PRE2_OK = (RATE_EFF == `DTC_RATE_A) || (RATE_EFF == `DTC_RATE_B)
        || (RATE_EFF == `DTC_RATE_C);
    localparam int GEAR_MIN = MOD_NCK + `DTC_GEAR_EXTRA_NCK;

    // counter lanes
    localparam int LN_WRPD = 0;
    localparam int LN_WTRS = 1;
    localparam int LN_WTRL = 2;
    localparam int LN_MR7 = 3;
    localparam int LN_SYNC = 4;
    localparam int LANES = 5;

    dtc_host_t h, next_h;
    dtc_link_t l, next_l;
    logic [1:0] to_link;
    logic [1:0] to_host;
    logic [23:0] cfg_l;
    logic lrst;
    logic [LANES-1:0] ld;
    logic [LANES*8-1:0] ldv;
    logic [LANES-1:0] cnt_idle;
    dtc_cmd_t c;
    logic [4:0] wl;
    logic [7:0] wr_end;
    logic [7:0] rec;
    logic [7:0] wtrs;
    logic [7:0] wtrl;
    logic crcdm;
    logic refuse;
    logic block;
    logic [16:0] pin_addr;
    logic [31:0] stat_word;
    logic [31:0] cmd_word;

    // ****************************************
    // crossings
    // ****************************************
    // command fields are read in the link domain only while the toggle
    // handshake keeps them frozen; cfg is quasi-static
    dtc_sync #(.W(2)) u_to_link (
        .clk(link_clk),
        .d({h.req, srst}),
        .q(to_link)
    );

    dtc_sync #(.W(24)) u_cfg (
        .clk(link_clk),
        .d(h.cfg),
        .q(cfg_l)
    );

    dtc_sync #(.W(2)) u_to_host (
        .clk(mclk),
        .d({l.ack, l.late}),
        .q(to_host)
    );

    assign lrst = to_link[0];

    // ****************************************
    // software register side
    // ****************************************
    always_comb begin : host_next
        stat_word = '0;
        stat_word[`DTC_STAT_BUSY] = h.busy;
        stat_word[`DTC_STAT_REFUSED] = h.refused;
        stat_word[`DTC_STAT_LATE] = h.late;
        stat_word[`DTC_STAT_PREBAD] = !PRE2_OK
            && (h.cfg[`DTC_CFG_RPRE] || h.cfg[`DTC_CFG_WPRE]);
        cmd_word = '0;
        cmd_word[3:0] = h.cmd;
        cmd_word[`DTC_CMD_BG_LSB +: 2] = h.bg;
        cmd_word[`DTC_CMD_ADDR_LSB +: 17] = h.addr;
        next_h = h;
        next_h.rdata = '0;
        if (to_host[1] != h.ack_seen) begin
            next_h.ack_seen = to_host[1];
            next_h.busy = 1'b0;
            next_h.refused = l.refused;
        end
        if (rd) begin
            case (addr)
                `DTC_REG_CMD: next_h.rdata = cmd_word;
                `DTC_REG_CFG: next_h.rdata = {8'h00, h.cfg};
                `DTC_REG_STAT: next_h.rdata = stat_word;
                default: next_h.rdata = '0;
            endcase
        end
        if (wr) begin
            case (addr)
                `DTC_REG_CMD: begin
                    // a new order while one is in flight is dropped
                    if (!h.busy) begin
                        next_h.cmd = wdata[3:0];
                        next_h.bg = wdata[`DTC_CMD_BG_LSB +: 2];
                        next_h.addr = wdata[`DTC_CMD_ADDR_LSB +: 17];
                        next_h.req = !h.req;
                        next_h.busy = 1'b1;
                    end
                end
                // reserved bits are never stored, so they read back as zero
                `DTC_REG_CFG: next_h.cfg = wdata[23:0] & `DTC_CFG_USED;
                `DTC_REG_STAT: begin
                    if (wdata[`DTC_STAT_LATE]) begin
                        next_h.late = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // set beats clear in the same cycle
        if (to_host[0]) begin
            next_h.late = 1'b1;
        end
        if (srst) begin
            next_h = '0;
        end
    end

    always_ff @(posedge mclk) begin
        h <= next_h;
    end

    // ****************************************
    // link side command engine
    // ****************************************
    always_comb begin : link_decode
        c = dtc_cmd_t'(h.cmd);
        wl = cfg_l[`DTC_CFG_WL_LSB +: 5];
        crcdm = cfg_l[`DTC_CFG_CRC] && cfg_l[`DTC_CFG_MASK];
        wr_end = 8'({3'b000, wl}) + (cfg_l[`DTC_CFG_BC4F] ? 8'(`DTC_BC4_START_NCK)
            : 8'(`DTC_BL8_START_NCK));
        if (crcdm) begin
            rec = 8'(WRCD_CYC);
        end else if (cfg_l[`DTC_CFG_MR0WR]) begin
            rec = {3'b000, cfg_l[`DTC_CFG_MR0_LSB +: 5]};
        end else begin
            rec = 8'(WR_CYC);
        end
        wtrs = crcdm ? 8'(WTRSCD_CYC) : 8'(WTRS_CYC);
        wtrl = crcdm ? 8'(WTRLCD_CYC) : 8'(WTRL_CYC);
        refuse = ((dtc_is_read(c) || c == DTC_ODT) && !cfg_l[`DTC_CFG_DLL])
            || (c == DTC_SYNC && !l.gear_armed);
        // powerdown entry is not held back by open activate, precharge
        // or refresh work; the device finishes those itself
        block = (!cnt_idle[LN_MR7] && c != DTC_MRS && c != DTC_GMRS)
            || !cnt_idle[LN_SYNC]
            || (c == DTC_PDE && !cnt_idle[LN_WRPD])
            || (dtc_is_read(c) && (!cnt_idle[LN_WTRS]
                || (h.bg == l.last_wr_bg && !cnt_idle[LN_WTRL])))
            || (c == DTC_SYNC && ((9'(l.gear_el) + 9'h001) < 9'(GEAR_MIN)
                || !l.gear_el[0]));
        pin_addr = h.addr;
        if ((c == DTC_MRS) && (h.addr[`DTC_MR_SEL_LSB +: 3] == `DTC_MR_FOUR)) begin
            pin_addr[`DTC_A_RPRE] = cfg_l[`DTC_CFG_RPRE] && PRE2_OK;
            pin_addr[`DTC_A_WPRE] = cfg_l[`DTC_CFG_WPRE] && PRE2_OK;
        end
    end

    always_comb begin : link_next
        next_l = l;
        ld = '0;
        ldv = '0;
        next_l.cmd_o = DTC_NOP;
        if (l.wr_since != 8'hFF) next_l.wr_since = l.wr_since + 8'h01;
        if (l.gear_el != 8'hFF) next_l.gear_el = l.gear_el + 8'h01;
        if (l.sync_since != 8'hFF) next_l.sync_since = l.sync_since + 8'h01;
        if (l.refi != 16'hFFFF) next_l.refi = l.refi + 16'h0001;
        next_l.late = (32'(l.refi) >= REFI_CYC);
        case (l.state)
            DTC_L_IDLE: begin
                if (to_link[1] != l.req_seen) begin
                    next_l.req_seen = to_link[1];
                    next_l.state = DTC_L_WAIT;
                end
            end
            DTC_L_WAIT: begin
                if (refuse) begin
                    next_l.ack = !l.ack;
                    next_l.refused = 1'b1;
                    next_l.state = DTC_L_IDLE;
                end else if (!block) begin
                    next_l.ack = !l.ack;
                    next_l.refused = 1'b0;
                    next_l.state = DTC_L_ACK;
                    next_l.cmd_o = (c == DTC_GMRS) ? DTC_MRS : c;
                    next_l.bg_o = h.bg;
                    next_l.addr_o = pin_addr;
                    case (c)
                        DTC_WR, DTC_WRA: begin
                            ld[LN_WRPD] = 1'b1;
                            ldv[LN_WRPD*8 +: 8] = wr_end + rec - 8'h01;
                            ld[LN_WTRS] = 1'b1;
                            ldv[LN_WTRS*8 +: 8] = wr_end + wtrs - 8'h01;
                            ld[LN_WTRL] = 1'b1;
                            ldv[LN_WTRL*8 +: 8] = wr_end + wtrl - 8'h01;
                            next_l.last_wr_bg = h.bg;
                            next_l.wr_since = '0;
                        end
                        DTC_MRS: begin
                            if (h.addr[`DTC_MR_SEL_LSB +: 3] == `DTC_MR_SEVEN) begin
                                ld[LN_MR7] = 1'b1;
                                ldv[LN_MR7*8 +: 8] = 8'(`DTC_MR7_NCK - 1);
                            end
                        end
                        DTC_GMRS: begin
                            next_l.gear_armed = 1'b1;
                            next_l.gear_el = '0;
                        end
                        DTC_SYNC: begin
                            next_l.gear_armed = 1'b0;
                            next_l.sync_since = '0;
                            ld[LN_SYNC] = 1'b1;
                            ldv[LN_SYNC*8 +: 8] = 8'(MOD_NCK - 1);
                        end
                        DTC_PDE: next_l.cke = 1'b0;
                        DTC_PDX: next_l.cke = 1'b1;
                        DTC_REF: next_l.refi = '0;
                        default: ;
                    endcase
                end
            end
            DTC_L_ACK: next_l.state = DTC_L_IDLE;
            default: next_l.state = DTC_L_IDLE;
        endcase
        if (lrst) begin
            next_l = '0;
            next_l.state = DTC_L_IDLE;
            next_l.wr_since = 8'hFF;
            next_l.gear_el = 8'hFF;
            next_l.sync_since = 8'hFF;
        end
    end

    always_ff @(posedge link_clk) begin
        l <= next_l;
    end

    dtc_cnt #(.N(LANES), .W(8)) u_cnt (
        .clk(link_clk),
        .rst(lrst),
        .load(ld),
        .value(ldv),
        .idle(cnt_idle)
    );

    assign rdata = h.rdata;
    assign ddr_cmd = l.cmd_o;
    assign ddr_bg = l.bg_o;
    assign ddr_addr = l.addr_o;
    assign ddr_cke = l.cke;

    // ****************************************
    // checks on the pins
    // ****************************************
    sequence s_mr7_sent;
        (ddr_cmd == DTC_MRS) && (ddr_addr[`DTC_MR_SEL_LSB +: 3] == `DTC_MR_SEVEN);
    endsequence

    sequence s_only_mrs;
        ((ddr_cmd == DTC_NOP) || (ddr_cmd == DTC_MRS))[*4];
    endsequence

    property p_dll_gate;
        @(posedge link_clk) disable iff (lrst)
        (dtc_is_read(ddr_cmd) || ddr_cmd == DTC_ODT) |-> $past(cfg_l[`DTC_CFG_DLL]);
    endproperty
    a_dll_gate: assert property (p_dll_gate) else $error("read issued without DLL lock");

    property p_mr7_gap;
        @(posedge link_clk) disable iff (lrst)
        s_mr7_sent |=> s_only_mrs;
    endproperty
    a_mr7_gap: assert property (p_mr7_gap) else $error("command too soon after MR7");

    property p_wr_pd;
        @(posedge link_clk) disable iff (lrst)
        (ddr_cmd == DTC_PDE) |-> (9'(l.wr_since) >= 9'(wr_end) + 9'(rec));
    endproperty
    a_wr_pd: assert property (p_wr_pd) else $error("powerdown too soon after write");

    property p_wtr;
        @(posedge link_clk) disable iff (lrst)
        dtc_is_read(ddr_cmd) |-> (9'(l.wr_since) >= 9'(wr_end) + 9'(wtrs))
            && ((ddr_bg != l.last_wr_bg) || (9'(l.wr_since) >= 9'(wr_end) + 9'(wtrl)));
    endproperty
    a_wtr: assert property (p_wtr) else $error("read too soon after write");

    property p_gear_even;
        @(posedge link_clk) disable iff (lrst)
        (ddr_cmd == DTC_SYNC) |-> !l.gear_el[0];
    endproperty
    a_gear_even: assert property (p_gear_even) else $error("sync interval odd");

    property p_gear_wait;
        @(posedge link_clk) disable iff (lrst)
        (ddr_cmd == DTC_SYNC) |-> (32'(l.gear_el) >= GEAR_MIN) && $past(l.gear_armed);
    endproperty
    a_gear_wait: assert property (p_gear_wait) else $error("sync too soon");

    property p_sync_quiet;
        @(posedge link_clk) disable iff (lrst)
        (ddr_cmd != DTC_NOP && ddr_cmd != DTC_SYNC) |-> (32'(l.sync_since) >= MOD_NCK);
    endproperty
    a_sync_quiet: assert property (p_sync_quiet) else $error("command too soon after sync");

    property p_pre_gate;
        @(posedge link_clk) disable iff (lrst)
        ((ddr_cmd == DTC_MRS) && (ddr_addr[`DTC_MR_SEL_LSB +: 3] == `DTC_MR_FOUR))
            |-> PRE2_OK || (!ddr_addr[`DTC_A_RPRE] && !ddr_addr[`DTC_A_WPRE]);
    endproperty
    a_pre_gate: assert property (p_pre_gate) else $error("two-cycle preamble at bad rate");

    property p_refi_flag;
        @(posedge link_clk) disable iff (lrst)
        (32'(l.refi) >= REFI_CYC + 1) |-> l.late;
    endproperty
    a_refi_flag: assert property (p_refi_flag) else $error("refresh lateness not flagged");

endmodule // dtc_top

// ===== testbench/dtc_dev_model.sv
`timescale 1ns/10ps
// ****************************************
// dram side: mode state and command spacing watch
// ****************************************
module dtc_dev_model
    import dtc_pkg::*;
#(
    parameter int WL = 8,
    parameter int MOD = 9,
    parameter bit BC4F = 1'b0
) (
    input wire logic link_clk,
    input wire logic [3:0] ddr_cmd,
    input wire logic [16:0] ddr_addr,
    input wire logic ddr_cke,
    output logic [1:0] rd_pre,
    output int viol
);
    int mrs_age = 99;
    int mr7_age = 99;
    int sync_age = 99;
    int wr_cnt = 0;
    logic [1:0] wr_pre = 2'h1;
    logic pd = 1'b0;
    initial rd_pre = 2'h1;
    initial viol = 0;
    always @(posedge link_clk) begin
        mrs_age++;
        mr7_age++;
        sync_age++;
        // internal write begins when this reaches zero
        if (wr_cnt > 0) wr_cnt--;
        if (ddr_cmd == DTC_PDX) pd = 1'b0;
        if (ddr_cmd != DTC_NOP) begin
            if (ddr_cmd != DTC_MRS && mr7_age < 5) viol++;
            if (sync_age < MOD) viol++;
            if (ddr_cmd == DTC_SYNC && (mrs_age < MOD + 4 || mrs_age[0])) viol++;
            if (ddr_cmd == DTC_WR || ddr_cmd == DTC_WRA) wr_cnt = WL + (BC4F ? 2 : 4);
            // entry taken even with row work pending; it finishes first
            if (ddr_cmd == DTC_PDE) pd = 1'b1;
            if (ddr_cmd == DTC_SYNC) sync_age = 0;
            if (ddr_cmd == DTC_MRS) begin
                mrs_age = 0;
                if (ddr_addr[16:14] == 3'h7) mr7_age = 0;
                if (ddr_addr[16:14] == 3'h4) begin
                    // two-cycle mode leaves hi-z a cycle early
                    rd_pre = ddr_addr[11] ? 2'h2 : 2'h1;
                    wr_pre = ddr_addr[12] ? 2'h2 : 2'h1;
                end
            end
        end
    end
endmodule // dtc_dev_model

// ===== testbench/dtc_top_test.sv
`timescale 1ns/10ps
module dtc_top_test;
    import dtc_pkg::*;
    typedef struct {logic [3:0] c; logic [16:0] a; int lo;} dtc_note_t;
    logic mclk = 1'b0, srst = 1'b1, link_clk = 1'b0, wr = 1'b0, rd = 1'b0, rd_p = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, last_rd, cfg, d;
    logic [3:0] ddr_cmd;
    logic [1:0] ddr_bg, rd_pre;
    logic [16:0] ddr_addr;
    logic ddr_cke;
    int err_total = 0, n_tests = 0, cyc = 0, lcyc = 0, last_c = 0, viol, s;
    logic [63:0] rq[$];
    dtc_note_t cq[$];
    logic [31:0] cf_t[7] = '{32'h0804, 32'h080C, 32'h0807, 32'h0C0814, 32'h0804, 32'h0804, 32'h0807};
    logic [3:0] c2_t[7] = '{4'h9, 4'h9, 4'h9, 4'h9, 4'h2, 4'h2, 4'h2};
    logic [1:0] b2_t[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1};
    int lo_t[7] = '{20, 18, 22, 24, 14, 16, 17};
    logic [3:0] rc_t[3] = '{4'h2, 4'h3, 4'hC};
    logic [3:0] pc_t[3] = '{4'h1, 4'h6, 4'h7};

    initial forever #20 mclk = ~mclk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end

    dtc_top #(.TCK_PS(2000), .MOD_NCK(9)) dut (.mclk(mclk), .srst(srst), .link_clk(link_clk),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ddr_cmd(ddr_cmd),
        .ddr_bg(ddr_bg), .ddr_addr(ddr_addr), .ddr_cke(ddr_cke));
    dtc_dev_model #(.WL(8), .MOD(9)) dram (.link_clk(link_clk), .ddr_cmd(ddr_cmd),
        .ddr_addr(ddr_addr), .ddr_cke(ddr_cke), .rd_pre(rd_pre), .viol(viol));

    // ****************************************
    // compares and bus tasks
    // ****************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // gap upper bound: a blocked command must go out soon after its wait ends
    task automatic cmp_cmd(input logic [3:0] c, input logic [16:0] a, input int gap,
        input dtc_note_t n);
        int hi;
        hi = (n.lo > 10 ? n.lo : 10) + 4;
        cmp({c, 11'h0, a}, {n.c, 11'h0, n.a});
        cmp((n.lo < 0 || (gap >= n.lo && gap <= hi)) ? 32'(n.lo) : 32'(gap), 32'(n.lo));
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, e});
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic setc(input logic [31:0] v);
        cfg = v;
        wreg(8'h04, v);
    endtask

    // one command; waits for busy to drop, then checks the refused flag
    task automatic dcmd(input logic [3:0] c, input logic [1:0] bg, input logic [16:0] a,
        input int lo, input logic ok);
        logic [16:0] pa;
        int k;
        pa = a;
        if (c == DTC_MRS && a[16:14] == 3'h4) begin
            pa[11] = cfg[5];
            pa[12] = cfg[6];
        end
        if (ok) cq.push_back('{(c == DTC_GMRS) ? DTC_MRS : c, pa, lo});
        wreg(8'h00, {9'h0, a, bg, c});
        k = 0;
        do begin
            rreg(8'h08, 32'h0, 32'h0);
            k++;
        end while (last_rd[0] !== 1'b0 && k < 300);
        if (k == 300) err_total++;
        rreg(8'h08, {30'h0, !ok, 1'b0}, 32'h2);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // watchers
    // ****************************************
    always @(negedge mclk) begin
        logic [63:0] e;
        if (rd_p) begin
            e = rq.pop_front();
            last_rd = rdata;
            if (e[63:32] != 32'h0) cmp(rdata & e[63:32], e[31:0]);
        end
        rd_p = rd;
    end

    always @(posedge link_clk) begin
        lcyc++;
        if (!srst && ddr_cmd !== 4'h0) begin
            if (cq.size() == 0) cmp_cmd(ddr_cmd, ddr_addr, 0, '{4'h0, 17'h0, -1});
            else cmp_cmd(ddr_cmd, ddr_addr, lcyc - last_c, cq.pop_front());
            last_c = lcyc;
        end
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            end_of_test();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        s = $urandom(6);
        cfg = 32'h0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (10) @(posedge mclk);
        rreg(8'h08, 32'h0, 32'hF);
        d = $urandom;
        wreg(8'h04, d);
        rreg(8'h04, d & 32'h001F1F7F, 32'hFFFFFFFF);
        wreg(8'h0C, 32'hFFFFFFFF);
        rreg(8'h0C, 32'h0, 32'hFFFFFFFF);
        rreg(8'h04, d & 32'h001F1F7F, 32'hFFFFFFFF);
        $display("test registers done");
        setc(32'h0800);
        dcmd(DTC_PDX, 2'h0, 17'h0, -1, 1'b1);
        cmp({31'h0, ddr_cke}, 32'h1);
        for (int i = 0; i < 3; i++) dcmd(rc_t[i], 2'h0, 17'($urandom), 0, 1'b0);
        setc(32'h0804);
        dcmd(DTC_RD, 2'h3, 17'h0155, -1, 1'b1);
        rreg(8'h00, {9'h0, 17'h0155, 2'h3, 4'h2}, 32'hFFFFFFFF);
        $display("test dll done");
        for (int i = 0; i < 7; i++) begin
            setc(cf_t[i]);
            dcmd(DTC_WR, 2'h1, 17'($urandom), -1, 1'b1);
            dcmd(c2_t[i], b2_t[i], 17'($urandom), lo_t[i], 1'b1);
            if (c2_t[i] == DTC_PDE) dcmd(DTC_PDX, 2'h0, 17'h0, -1, 1'b1);
        end
        $display("test write spacing done");
        setc(32'h0804);
        for (int i = 0; i < 3; i++) begin
            dcmd(pc_t[i], 2'($urandom), 17'($urandom), -1, 1'b1);
            dcmd(DTC_PDE, 2'h0, 17'h0, 0, 1'b1);
            cmp({31'h0, ddr_cke}, 32'h0);
            dcmd(DTC_PDX, 2'h0, 17'h0, -1, 1'b1);
        end
        $display("test powerdown done");
        setc(32'h0864);
        dcmd(DTC_MRS, 2'h0, 17'h10000, -1, 1'b1);
        cmp({30'h0, rd_pre}, 32'h2);
        rreg(8'h08, 32'h0, 32'h8);
        setc(32'h0804);
        dcmd(DTC_MRS, 2'h0, 17'h11800, -1, 1'b1);
        dcmd(DTC_MRS, 2'h0, 17'h1C000, -1, 1'b1);
        dcmd(DTC_ACT, 2'h2, 17'($urandom), 5, 1'b1);
        $display("test mode registers done");
        dcmd(DTC_SYNC, 2'h0, 17'h0, 0, 1'b0);
        dcmd(DTC_GMRS, 2'h0, 17'h0C008, -1, 1'b1);
        dcmd(DTC_SYNC, 2'h0, 17'h0, 14, 1'b1);
        dcmd(DTC_ACT, 2'h1, 17'($urandom), 9, 1'b1);
        $display("test geardown done");
        repeat (4000) @(posedge link_clk);
        rreg(8'h08, 32'h4, 32'h4);
        dcmd(DTC_REF, 2'h0, 17'h0, -1, 1'b1);
        wreg(8'h08, 32'h4);
        rreg(8'h08, 32'h0, 32'h4);
        $display("test refresh done");
        cmp(32'(viol), 32'h0);
        cmp(32'(cq.size()), 32'h0);
        end_of_test();
    end
endmodule // dtc_top_test
